// ===== flash_read_engine.sv
// read-command engine of a serial flash: quad output, dual io and quad io reads
// assumes sck period is at least four ref_clk periods and that the
// array answers a fetch with mem_rdata in the same cycle as mem.req
//
// Overview of operation
// - 6Bh quad output, 6Ch always four-byte
// - latency code sets quad output dummies
// - lines ignored and undriven during dummies
// - quad output: nibble per falling edge
// - dummies separate address from data; latency code zero gives none
// - address increments per byte, wraps to zero
// - BBh dual io, BCh always four-byte
// - dual io address and data on two lines
// - instruction, address, four mode clocks, latency
// - dual io latency after mode, lines ignored
// - dual io: bit pair per falling edge
// - mode Ax keeps dual continuous read
// - other mode value exits at cs rise
// - mode reset command leaves continuous read
// - EBh quad io, ECh always four-byte
// - quad io needs quad enable or protocol
// - quad io: two mode clocks, dummies, nibbles
// - mode Ax keeps quad continuous read
// - quad protocol: instruction four bits per rise
// - address-length bit widens legacy opcodes
// - dummies counted falling edge to falling edge
`timescale 1ns/100ps
`default_nettype none

module flash_read_engine
    import flash_read_pkg::*;
#(
    parameter logic [31:0] ARRAY_LAST = ARRAY_LAST_RST  // highest array byte address
) (
    // clock and reset
    input  wire logic                       ref_clk,
    input  wire logic                       rst,
    // serial pins
    input  wire logic                       sck,
    input  wire logic                       cs_n,
    input  wire logic [3:0]                 io_in,
    output logic      [3:0]                 io_out,
    output logic      [3:0]                 io_oe,
    // configuration bits
    input  wire flash_read_pkg::cfg_t       cfg,
    // array fetch port
    output flash_read_pkg::mem_req_t        mem,
    input  wire logic [7:0]                 mem_rdata,
    // status
    output logic                            read_active,
    output logic                            execute_in_place
);

    // ************************************************************
    // pin synchronisation
    // ************************************************************
    logic [5:0] pins_s;   // {sck, cs_n, io} after two flops
    logic       sck_s;
    logic       cs_s;
    logic [3:0] io_s;

    // cs resets high so no false select edge follows reset
    pin_sync #(
        .W       (6),
        .RST_VAL (6'h10)
    ) u_sync (
        .ref_clk (ref_clk),
        .rst     (rst),
        .d       ({sck, cs_n, io_in}),
        .q       (pins_s)
    );

    assign sck_s = pins_s[5];
    assign cs_s  = pins_s[4];
    assign io_s  = pins_s[3:0];

    // ************************************************************
    // state and edge decode
    // ************************************************************
    state_t s_r;        // all engine state
    state_t s_nxt;      // its next value
    logic   rise;       // sck rising edge seen
    logic   fall;       // sck falling edge seen
    logic   cs_fall;    // select asserted
    logic   cs_rise;    // select released
    logic [5:0] cmd_step;   // instruction bits per rise
    logic [5:0] cmd_cnt;    // instruction bits after this rise
    logic [7:0] op_now;     // instruction with this rise's bits
    logic       cmd_done;   // last instruction bit arrives now
    logic [5:0] addr_lanes; // address bits per rise
    logic [5:0] addr_len;   // address length in bits
    logic [5:0] mode_len;   // mode clocks of this command
    logic [31:0] addr_inc;  // next sequential address

    assign rise    = sck_s & ~s_r.sck_d;
    assign fall    = ~sck_s & s_r.sck_d;
    assign cs_fall = ~cs_s & s_r.cs_d;
    assign cs_rise = cs_s & ~s_r.cs_d;

    // instruction shifts in one bit, or a nibble in quad protocol
    assign cmd_step = cfg.quad_protocol ? 6'h04 : 6'h01;
    assign cmd_cnt  = s_r.cnt + cmd_step;
    assign cmd_done = (cmd_cnt == CMD_BITS);
    assign op_now   = cfg.quad_protocol ? {s_r.shift[3:0], io_s} : {s_r.shift[6:0], io_s[0]};

    // address lanes follow the read kind
    always_comb begin
        case (s_r.kind)
            RD_DUAL_IO: addr_lanes = 6'h02;
            RD_QUAD_IO: addr_lanes = 6'h04;
            default:    addr_lanes = 6'h01;
        endcase
    end

    assign addr_len = s_r.wide ? ADDR_BITS_WIDE : ADDR_BITS_SHORT;
    assign mode_len = (s_r.kind == RD_DUAL_IO) ? DUAL_MODE_CYCLES : QUAD_MODE_CYCLES;
    // the counter rolls back to zero past the last array byte
    assign addr_inc = (s_r.addr == ARRAY_LAST) ? '0 : s_r.addr + 32'h1;

    // ************************************************************
    // next-state logic
    // ************************************************************
    always_comb begin
        logic        data_go;   // drive a data unit on this fall
        logic        fetch;     // start the first array fetch
        logic [31:0] sh_addr;   // address shift with this rise
        logic [7:0]  byte_now;  // byte being shifted out
        data_go  = 1'b0;
        fetch    = 1'b0;
        sh_addr  = '0;
        byte_now = '0;
        s_nxt    = s_r;
        s_nxt.sck_d   = sck_s;
        s_nxt.cs_d    = cs_s;
        s_nxt.mem.req = 1'b0;
        // array answers in the cycle the request stands on mem
        if (s_r.mem.req) begin
            s_nxt.next_byte = mem_rdata;
        end
        case (s_r.st)
            // instruction phase
            ST_CMD: begin
                if (rise) begin
                    s_nxt.shift = {24'h0, op_now};
                    s_nxt.cnt   = cmd_cnt;
                    if (cmd_done) begin
                        s_nxt.cnt   = '0;
                        s_nxt.shift = '0;
                        s_nxt.st    = ST_IDLE;
                        // wide-address opcodes are the even ones of each pair
                        s_nxt.wide  = cfg.addr_len_wide | ~op_now[0];
                        case (op_now)
                            OP_QUAD_OUTPUT_READ, OP_QUAD_OUTPUT_READ_WIDE_ADDR: begin
                                if (!cfg.quad_protocol) begin
                                    s_nxt.kind = RD_QUAD_OUT;
                                    s_nxt.st   = ST_ADDR;
                                end
                            end
                            OP_DUAL_IO_READ, OP_DUAL_IO_READ_WIDE_ADDR: begin
                                if (!cfg.quad_protocol) begin
                                    s_nxt.kind = RD_DUAL_IO;
                                    s_nxt.st   = ST_ADDR;
                                end
                            end
                            OP_QUAD_IO_READ, OP_QUAD_IO_READ_WIDE_ADDR: begin
                                // refused quietly: device just waits for cs rise
                                if (cfg.quad_enable || cfg.quad_protocol) begin
                                    s_nxt.kind = RD_QUAD_IO;
                                    s_nxt.st   = ST_ADDR;
                                end
                            end
                            OP_MODE_RESET: begin
                                s_nxt.cont_on = 1'b0;
                            end
                            default: begin
                                s_nxt.st = ST_IDLE;
                            end
                        endcase
                    end
                end
            end
            // address phase, one, two or four lanes
            ST_ADDR: begin
                if (rise) begin
                    case (s_r.kind)
                        RD_DUAL_IO: sh_addr = {s_r.shift[29:0], io_s[1:0]};
                        RD_QUAD_IO: sh_addr = {s_r.shift[27:0], io_s};
                        default:    sh_addr = {s_r.shift[30:0], io_s[0]};
                    endcase
                    s_nxt.shift = sh_addr;
                    s_nxt.cnt   = s_r.cnt + addr_lanes;
                    if (!io_s[0]) begin
                        s_nxt.ones = 1'b0;
                    end
                    if (s_nxt.cnt == addr_len) begin
                        s_nxt.addr = sh_addr;
                        s_nxt.cnt  = '0;
                        if (s_r.kind == RD_QUAD_OUT) begin
                            fetch = 1'b1;
                        end else begin
                            s_nxt.st = ST_MODE;
                        end
                    end
                end
            end
            // mode bits, upper nibble decides continuous read
            ST_MODE: begin
                if (rise) begin
                    if (s_r.kind == RD_DUAL_IO) begin
                        s_nxt.mode = {s_r.mode[5:0], io_s[1:0]};
                    end else begin
                        s_nxt.mode = {s_r.mode[3:0], io_s};
                    end
                    s_nxt.cnt = s_r.cnt + 6'h01;
                    if (s_nxt.cnt == mode_len) begin
                        s_nxt.cnt       = '0;
                        s_nxt.mode_done = 1'b1;
                        fetch           = 1'b1;
                    end
                end
            end
            // dummies: lines ignored, counted fall to fall
            ST_DUMMY: begin
                if (fall) begin
                    if (s_r.cnt == {2'b00, cfg.latency_code}) begin
                        data_go = 1'b1;
                    end else begin
                        s_nxt.cnt = s_r.cnt + 6'h01;
                    end
                end
            end
            // data output on falling edges
            ST_DATA: begin
                if (fall) begin
                    data_go = 1'b1;
                end
            end
            default: begin
                s_nxt.st = ST_IDLE;
            end
        endcase
        // first fetch: the latency hides the array access
        if (fetch) begin
            s_nxt.st       = ST_DUMMY;
            s_nxt.units    = '0;
            s_nxt.mem.req  = 1'b1;
            s_nxt.mem.addr = s_nxt.addr;
        end
        // one data unit, msb first on the top active lane
        if (data_go) begin
            s_nxt.st = ST_DATA;
            byte_now = (s_r.units == '0) ? s_r.next_byte : s_r.out_sh;
            if (s_r.units == '0) begin
                s_nxt.mem.req  = 1'b1;
                s_nxt.mem.addr = addr_inc;
                s_nxt.addr     = addr_inc;
            end
            if (s_r.kind == RD_DUAL_IO) begin
                s_nxt.io_o   = {2'b00, byte_now[7:6]};
                s_nxt.out_sh = {byte_now[5:0], 2'b00};
                s_nxt.io_oe  = LANES_DUAL;
                s_nxt.units  = (s_r.units == '0) ? DUAL_UNITS - 3'h1 : s_r.units - 3'h1;
            end else begin
                s_nxt.io_o   = byte_now[7:4];
                s_nxt.out_sh = {byte_now[3:0], 4'h0};
                s_nxt.io_oe  = LANES_QUAD;
                s_nxt.units  = (s_r.units == '0) ? QUAD_UNITS - 3'h1 : s_r.units - 3'h1;
            end
        end
        // select asserted: continuous read skips the instruction
        if (cs_fall) begin
            s_nxt.cnt       = '0;
            s_nxt.shift     = '0;
            s_nxt.mode_done = 1'b0;
            s_nxt.units     = '0;
            s_nxt.ones      = 1'b1;
            if (s_r.cont_on) begin
                s_nxt.st   = ST_ADDR;
                s_nxt.kind = s_r.cont_kind;
                s_nxt.wide = s_r.cont_wide;
            end else begin
                s_nxt.st = ST_CMD;
            end
        end
        // select high ends any read and frees the lines
        if (cs_s) begin
            s_nxt.st    = ST_IDLE;
            s_nxt.io_oe = '0;
        end
        // continuous state is settled at select release or by the mode reset command;
        // a release inside mode cycles keeps the old setting
        if (cs_rise) begin
            if (s_r.mode_done) begin
                s_nxt.cont_on   = (s_r.mode[7:4] == MODE_CONT_NIBBLE);
                s_nxt.cont_kind = s_r.kind;
                s_nxt.cont_wide = s_r.wide;
            end else if (s_r.cont_on && s_r.st == ST_ADDR && s_r.ones && s_r.cnt != '0) begin
                // ones on io0 at every rise, released before the address completes, is a mode reset
                s_nxt.cont_on = 1'b0;
            end
        end
    end

    // registers
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            s_r <= STATE_RST;
        end else begin
            s_r <= s_nxt;
        end
    end

    // ************************************************************
    // outputs
    // ************************************************************
    assign io_out           = s_r.io_o;
    assign io_oe            = s_r.io_oe;
    assign mem              = s_r.mem;
    assign read_active      = (s_r.st != ST_IDLE);
    assign execute_in_place = s_r.cont_on;

    // ************************************************************
    // assertions
    // ************************************************************
    logic data_go_chk;  // a data unit is driven this cycle
    assign data_go_chk = fall && (s_r.st == ST_DATA ||
                         (s_r.st == ST_DUMMY && s_r.cnt == {2'b00, cfg.latency_code}));

    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (rst);

    sequence s_cmd_end(logic [7:0] op);
        s_r.st == ST_CMD && rise && cmd_done && op_now == op;
    endsequence

    sequence s_mode_release;
        cs_rise && s_r.mode_done;
    endsequence

    property p_qor_decode;
        s_cmd_end(OP_QUAD_OUTPUT_READ) and !cfg.quad_protocol
            |=> s_r.st == ST_ADDR && s_r.kind == RD_QUAD_OUT && s_r.wide == $past(cfg.addr_len_wide);
    endproperty
    a_qor_decode: assert property (p_qor_decode) else $error("quad output decode wrong");

    property p_dummy_quiet;
        s_r.st == ST_DUMMY |-> s_r.io_oe == '0;
    endproperty
    a_dummy_quiet: assert property (p_dummy_quiet) else $error("lines driven in dummies");

    property p_data_start;
        s_r.st == ST_DUMMY && fall && s_r.cnt == {2'b00, cfg.latency_code} && !cs_s
            |=> s_r.st == ST_DATA && s_r.io_oe != '0;
    endproperty
    a_data_start: assert property (p_data_start) else $error("data start off");

    property p_quad_lanes;
        s_r.st == ST_DATA && s_r.kind != RD_DUAL_IO |-> s_r.io_oe == LANES_QUAD;
    endproperty
    a_quad_lanes: assert property (p_quad_lanes) else $error("quad lanes wrong");

    property p_dual_lanes;
        s_r.st == ST_DATA && s_r.kind == RD_DUAL_IO |-> s_r.io_oe == LANES_DUAL;
    endproperty
    a_dual_lanes: assert property (p_dual_lanes) else $error("dual lanes wrong");

    property p_wrap;
        data_go_chk && s_r.units == '0 && s_r.addr == ARRAY_LAST |=> s_r.addr == '0 && s_r.mem.req;
    endproperty
    a_wrap: assert property (p_wrap) else $error("address wrap missing");

    property p_cont_keep;
        s_mode_release and s_r.mode[7:4] == MODE_CONT_NIBBLE
            |=> s_r.cont_on [*2];
    endproperty
    a_cont_keep: assert property (p_cont_keep) else $error("continuous read lost");

    property p_cont_exit;
        s_mode_release and s_r.mode[7:4] != MODE_CONT_NIBBLE |=> !s_r.cont_on;
    endproperty
    a_cont_exit: assert property (p_cont_exit) else $error("continuous read kept");

    property p_mode_reset;
        s_cmd_end(OP_MODE_RESET) |=> !s_r.cont_on;
    endproperty
    a_mode_reset: assert property (p_mode_reset) else $error("mode reset ignored");

    property p_quad_gate;
        s_cmd_end(OP_QUAD_IO_READ) and !cfg.quad_enable && !cfg.quad_protocol |=> s_r.st == ST_IDLE;
    endproperty
    a_quad_gate: assert property (p_quad_gate) else $error("quad io not gated");

    property p_dual_mode_len;
        s_r.st == ST_MODE && s_r.kind == RD_DUAL_IO && rise && s_r.cnt == 6'h03 && !cs_s
            |=> s_r.st == ST_DUMMY && s_r.mem.req;
    endproperty
    a_dual_mode_len: assert property (p_dual_mode_len) else $error("dual mode length off");

endmodule // flash_read_engine

`default_nettype wire

// ===== flash_read_pkg.sv
// shared constants and types of the multi-lane flash read path
// assumes one 100 MHz reference clock; the serial clock is a sampled pin
package flash_read_pkg;

    // ************************************************************
    // command opcodes
    // ************************************************************
    localparam logic [7:0] OP_QUAD_OUTPUT_READ           = 8'h6b;
    localparam logic [7:0] OP_QUAD_OUTPUT_READ_WIDE_ADDR = 8'h6c;
    localparam logic [7:0] OP_DUAL_IO_READ               = 8'hbb;
    localparam logic [7:0] OP_DUAL_IO_READ_WIDE_ADDR     = 8'hbc;
    localparam logic [7:0] OP_QUAD_IO_READ               = 8'heb;
    localparam logic [7:0] OP_QUAD_IO_READ_WIDE_ADDR     = 8'hec;
    localparam logic [7:0] OP_MODE_RESET                 = 8'hff;

    // ************************************************************
    // field values and phase lengths
    // ************************************************************
    localparam logic [3:0] MODE_CONT_NIBBLE  = 4'ha;   // upper mode nibble that keeps continuous read
    localparam logic [5:0] CMD_BITS          = 6'h08;  // instruction length in bits
    localparam logic [5:0] ADDR_BITS_SHORT   = 6'h18;  // 3-byte address
    localparam logic [5:0] ADDR_BITS_WIDE    = 6'h20;  // 4-byte address
    localparam logic [5:0] DUAL_MODE_CYCLES  = 6'h04;  // mode clocks, two lanes
    localparam logic [5:0] QUAD_MODE_CYCLES  = 6'h02;  // mode clocks, four lanes
    localparam logic [2:0] DUAL_UNITS        = 3'h4;   // bit pairs per byte
    localparam logic [2:0] QUAD_UNITS        = 3'h2;   // nibbles per byte
    localparam logic [3:0] LANES_QUAD        = 4'hf;   // output enables, four lanes
    localparam logic [3:0] LANES_DUAL        = 4'h3;   // output enables, two lanes
    localparam logic [31:0] ARRAY_LAST_RST   = 32'h00ff_ffff; // default highest byte address

    // ************************************************************
    // types
    // ************************************************************
    typedef enum logic [5:0] {
        ST_IDLE  = 6'b000001,
        ST_CMD   = 6'b000010,
        ST_ADDR  = 6'b000100,
        ST_MODE  = 6'b001000,
        ST_DUMMY = 6'b010000,
        ST_DATA  = 6'b100000
    } phase_t;

    typedef enum logic [1:0] {
        RD_QUAD_OUT = 2'h0,
        RD_DUAL_IO  = 2'h1,
        RD_QUAD_IO  = 2'h2
    } read_kind_t;

    // static configuration bits from the configuration registers
    typedef struct packed {
        logic       addr_len_wide;  // 4-byte address for legacy opcodes
        logic       quad_enable;    // quad enable of config_reg1_volatile
        logic       quad_protocol;  // quad_protocol_mode of config_reg2_volatile
        logic [3:0] latency_code;   // dummy cycles from config_reg3_volatile
    } cfg_t;

    // array fetch request
    typedef struct packed {
        logic        req;
        logic [31:0] addr;
    } mem_req_t;

    // whole state of the read engine
    typedef struct packed {
        phase_t     st;
        read_kind_t kind;
        logic       wide;
        logic [5:0] cnt;
        logic [2:0] units;
        logic [31:0] shift;
        logic [31:0] addr;
        logic [7:0] mode;
        logic       mode_done;
        logic [7:0] out_sh;
        logic [7:0] next_byte;
        logic [3:0] io_o;
        logic [3:0] io_oe;
        logic       cont_on;
        read_kind_t cont_kind;
        logic       cont_wide;
        logic       ones;
        logic       sck_d;
        logic       cs_d;
        mem_req_t   mem;
    } state_t;

    localparam state_t STATE_RST = '{st: ST_IDLE, kind: RD_QUAD_OUT, cont_kind: RD_QUAD_OUT,
                                     cs_d: 1'b1, default: '0};

endpackage

// ===== pin_sync.sv
// two-stage synchroniser for a group of pins
// assumes the pins are asynchronous to ref_clk
`timescale 1ns/100ps
`default_nettype none

module pin_sync #(
    parameter int unsigned     W       = 1,
    parameter logic [W-1:0]    RST_VAL = '0
) (
    // clock and reset
    input  wire logic         ref_clk,
    input  wire logic         rst,
    // pins in, synchronised copy out
    input  wire logic [W-1:0] d,
    output logic      [W-1:0] q
);

    typedef struct packed {
        logic [W-1:0] s1;  // metastable stage, read only by s2
        logic [W-1:0] s2;  // settled stage
    } sync_t;

    sync_t s_r;
    sync_t s_nxt;

    // ************************************************************
    // next state
    // ************************************************************
    always_comb begin
        s_nxt.s1 = d;
        s_nxt.s2 = s_r.s1;
    end

    // registers
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            s_r <= '{s1: RST_VAL, s2: RST_VAL};
        end else begin
            s_r <= s_nxt;
        end
    end

    assign q = s_r.s2;

endmodule // pin_sync

`default_nettype wire

// ===== spi_host_model.sv
// host side of the serial link: sck, cs_n and the io lanes
// assumes 100 MHz ref_clk; sck half period is six ref_clk cycles
`timescale 1ns/100ps
`default_nettype none
module spi_host_model (
    // clock
    input  wire logic       ref_clk,
    // pins as driven and as seen
    output logic            sck,
    output logic            cs_n,
    output logic [3:0]      h_d,
    output logic            h_en,
    input  wire logic [3:0] io
);
    // sck stands low between frames, cs high
    initial begin
        {sck, cs_n, h_d, h_en} = 7'h20;
    end
    task automatic half();
        repeat (6) @(posedge ref_clk);
    endtask
    // cs edges land away from sck edges; cs only moves between frames
    task automatic frame(input logic v);
        half();
        cs_n <= v;
        half();
    endtask
    // msb first, l lanes per rise
    task automatic send(input int l, input int b, input logic [31:0] v);
        for (int i = b; i > 0; i -= l) begin
            h_d <= 4'((v >> (i - l)) & ((1 << l) - 1));
            h_en <= 1'b1;
            half();
            sck <= 1'b1;
            half();
            sck <= 1'b0;
        end
    endtask
    // release lanes at dummy fall 0, so never late for data
    task automatic dummies(input int n);
        h_en <= 1'b0;
        repeat (2 * n) begin
            half();
            sck <= ~sck;
        end
    endtask
    // one byte, sampled just before each rise
    task automatic recv(input int l, output logic [7:0] q);
        q = 8'h00;
        for (int i = 0; i < 8; i += l) begin
            half();
            q = (q << l) | 8'(io & 4'((1 << l) - 1));
            sck <= 1'b1;
            half();
            sck <= 1'b0;
        end
    endtask
endmodule // spi_host_model
`default_nettype wire

// ===== flash_read_engine_tb.sv
// bench: host model against the read engine, array model in line
// assumes the package and design files compile first
`timescale 1ns/100ps
`default_nettype none
module flash_read_engine_tb;
    import flash_read_pkg::*;
    localparam logic [31:0] LAST = 32'h0000_1fff; // small array, wraps soon
    logic ref_clk, rst, cs_n, sck, h_en, read_active, execute_in_place;
    logic [3:0] h_d, io_out, io_oe, io;
    logic [7:0] mem_rdata, got;
    cfg_t       cfg; // {wide, quad enable, quad protocol, latency}
    mem_req_t   mem;
    int         failures = 0, checks = 0;
    // device wins where it drives; a released host lane shows its inverse
    assign io = (io_oe & io_out) | (~io_oe & (h_en ? h_d : ~h_d));
    initial begin
        ref_clk = 1'b0;
        forever #5 ref_clk = ~ref_clk;
    end
    // array: byte mixes both low address bytes, so wrap shows;
    // answers while the fetch stands, where the engine takes it
    assign mem_rdata = mem.addr[7:0] ^ mem.addr[15:8];
    spi_host_model host (.ref_clk(ref_clk), .sck(sck), .cs_n(cs_n), .h_d(h_d),
        .h_en(h_en), .io(io));
    flash_read_engine #(.ARRAY_LAST(LAST)) uut (.ref_clk(ref_clk), .rst(rst), .sck(sck),
        .cs_n(cs_n), .io_in(io), .io_out(io_out), .io_oe(io_oe), .cfg(cfg), .mem(mem),
        .mem_rdata(mem_rdata), .read_active(read_active), .execute_in_place(execute_in_place));
    task automatic chk(input string n, input logic [7:0] e, input logic [7:0] g);
        checks++;
        if (g !== e) begin
            failures++;
            $display("[FAIL] %s expected %h seen %h", n, e, g);
        end
    endtask
    task automatic test_done();
        $display("checks %0d failures %0d", checks, failures);
        if (failures == 0 && checks > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask
    // frame: instruction on ol lanes (0: none), address, mode, dummies, n bytes
    task automatic rd(input int ol, input logic [7:0] op, input int al, input int ab,
        input logic [31:0] a, input int ml, input logic [7:0] md, input int dl, input int n);
        host.frame(1'b0);
        if (ol > 0) host.send(ol, 8, {24'h0, op});
        host.send(al, ab, a);
        if (ml > 0) host.send(ml, 8, {24'h0, md});
        host.dummies(int'(cfg.latency_code));
        for (int k = 0; k < n; k++) begin
            host.recv(dl, got);
            chk("byte", a[7:0] ^ a[15:8], got);
            a = (a == LAST) ? 32'h0 : a + 32'h1;
        end
        host.frame(1'b1);
    endtask
    initial begin
        rst <= 1'b1;
        cfg <= '0;
        repeat (2) @(posedge ref_clk);
        rst <= 1'b0;
        repeat (3) @(posedge ref_clk);
        cfg <= 7'h03;
        rd(1, OP_QUAD_OUTPUT_READ, 1, 24, 32'h1ffd, 0, 8'h0, 4, 4);
        cfg <= 7'h00;
        rd(1, OP_QUAD_OUTPUT_READ_WIDE_ADDR, 1, 32, 32'h0123, 0, 8'h0, 4, 2);
        cfg <= 7'h40;
        rd(1, OP_QUAD_OUTPUT_READ, 1, 32, 32'h0456, 0, 8'h0, 4, 1);
        cfg <= 7'h02;
        rd(1, OP_DUAL_IO_READ, 2, 24, 32'h0789, 2, 8'ha5, 2, 2);
        chk("cont on", 8'h01, {7'h0, execute_in_place});
        rd(0, 8'h0, 2, 24, 32'h1fff, 2, 8'h5a, 2, 2);
        chk("cont off", 8'h00, {7'h0, execute_in_place});
        rd(1, OP_DUAL_IO_READ_WIDE_ADDR, 2, 32, 32'h0abc, 2, 8'h00, 2, 1);
        host.frame(1'b0);
        host.send(1, 8, {24'h0, OP_QUAD_IO_READ});
        host.send(4, 8, 32'h0000_00ff);
        chk("refused", 8'h00, {3'h0, read_active, io_oe});
        host.frame(1'b1);
        cfg <= 7'h21;
        rd(1, OP_QUAD_IO_READ, 4, 24, 32'h0f0e, 4, 8'ha0, 4, 2);
        rd(0, 8'h0, 4, 24, 32'h0d0c, 4, 8'ha0, 4, 1);
        host.frame(1'b0);
        host.send(4, 8, {24'h0, OP_MODE_RESET});
        host.frame(1'b1);
        chk("reset mode", 8'h00, {7'h0, execute_in_place});
        host.frame(1'b0);
        host.send(1, 8, {24'h0, OP_MODE_RESET});
        host.frame(1'b1);
        chk("reset cmd", 8'h00, {7'h0, execute_in_place});
        cfg <= 7'h12;
        rd(4, OP_QUAD_IO_READ_WIDE_ADDR, 4, 32, 32'h1234, 4, 8'h00, 4, 2);
        test_done();
    end
    // hang guard
    initial begin
        repeat (100000) @(posedge ref_clk);
        failures++;
        test_done();
    end
endmodule // flash_read_engine_tb
`default_nettype wire
